// [core/mgmt_regs_pkg.sv]
`default_nettype none
package mgmt_regs_pkg;
	// address layout
	localparam int unsigned ADDR_W      = 16;
	localparam int unsigned DATA_W      = 8;
	localparam int unsigned TOP_BIT     = 15;
	localparam int unsigned PORT_LSB    = 12;
	localparam int unsigned PAGE_LSB    = 8;
	localparam int unsigned FIELD_W     = 4;
	localparam int unsigned NUM_SRC     = 4;
	localparam logic [3:0]  PORT_GLOBAL = 4'h0;
	localparam logic [3:0]  PORT_LAST   = 4'h7;
	// source indices
	localparam int unsigned SRC_SPI     = 0;
	localparam int unsigned SRC_I2C     = 1;
	localparam int unsigned SRC_INBAND  = 2;
	localparam int unsigned SRC_MIIM    = 3;
	// global pages
	localparam logic [3:0]  GPAGE_OPER  = 4'h0;
	localparam logic [3:0]  GPAGE_LAST  = 4'h4;
	// port pages
	localparam logic [3:0]  PPAGE_PHY   = 4'h1;
	localparam logic [3:0]  PPAGE_RSV_A = 4'h2;
	localparam logic [3:0]  PPAGE_RSV_B = 4'h7;
	localparam logic [3:0]  PPAGE_LAST  = 4'hb;
	// operation page offsets
	localparam logic [7:0]  OFF_IDENT0  = 8'h00;
	localparam logic [7:0]  OFF_IDENT_U = 8'h01;
	localparam logic [7:0]  OFF_IDENT_L = 8'h02;
	localparam logic [7:0]  OFF_REV_RST = 8'h03;
	localparam logic [7:0]  OFF_WAKE    = 8'h06;
	localparam logic [7:0]  OFF_ISTAT   = 8'h10;
	localparam logic [7:0]  OFF_IMASK   = 8'h14;
	// field positions
	localparam int unsigned REV_LSB     = 4;
	localparam int unsigned SRST_BIT    = 0;
	localparam int unsigned WAKE_EN_BIT = 1;
	localparam int unsigned WAKE_POL_BIT = 0;
	localparam int unsigned LOOKUP_IRQ_BIT = 31;
	// reset values
	localparam logic        SRST_RST    = 1'b0;
	localparam logic        WAKE_EN_RST = 1'b0;
	localparam logic        WAKE_POL_RST = 1'b0;
	localparam logic        IMASK_RST   = 1'b0;
	// timing
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned SRST_PULSE_NS = 40;
	localparam int unsigned SRST_CYCLES =
		(SRST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_WAIT = 2'b01
	} acc_state_t;

	typedef enum logic [1:0] {
		SR_IDLE   = 2'b00,
		SR_ACTIVE = 2'b01
	} srst_state_t;
endpackage
`default_nettype wire

// [core/mgmt_regs.sv]
`default_nettype none
// Function
// - spi, i2c, in-band reach whole space
// - miim reaches only port phy pages
// - address splits into port, page, offset
// - port zero global, ports one to seven
// - address bit fifteen always zero
// - every byte accessed alone, any order
// - most significant byte at lowest address
// - global pages zero to four, rest reserved
// - port pages 2, 7, c-f reserved
// - three identification bytes read only
// - revision in upper nibble, 3:1 zero
// - soft reset bit self clears, keeps registers
// - wake pin output enable bit
// - wake pin polarity bit
// - status bit 31 mirrors lookup engine request
// - mask bit 31 gates, zero enables
module mgmt_regs
#(
	parameter logic [7:0] IDENT_FIXED  = 8'h11, // arbitrary value
	parameter logic [7:0] IDENT_UPPER  = 8'h5a, // arbitrary value
	parameter logic [7:0] IDENT_LOWER  = 8'h3c, // arbitrary value
	parameter logic [3:0] SILICON_REV  = 4'h1,  // arbitrary value
	parameter int unsigned SRST_LEN    = mgmt_regs_pkg::SRST_CYCLES
) (
	input  wire logic                                   mclk_i,
	input  wire logic                                   rst_i,
	input  wire logic [mgmt_regs_pkg::NUM_SRC-1:0]      req_valid_i,
	input  wire logic [mgmt_regs_pkg::NUM_SRC-1:0]      req_we_i,
	input  wire logic [mgmt_regs_pkg::ADDR_W-1:0]       req_addr_i [mgmt_regs_pkg::NUM_SRC],
	input  wire logic [mgmt_regs_pkg::DATA_W-1:0]       req_wdata_i [mgmt_regs_pkg::NUM_SRC],
	output logic      [mgmt_regs_pkg::NUM_SRC-1:0]      req_ready_o,
	output logic      [mgmt_regs_pkg::NUM_SRC-1:0]      ack_o,
	output logic      [mgmt_regs_pkg::DATA_W-1:0]       rdata_o,
	output logic                                        dn_req_o,
	output logic                                        dn_we_o,
	output logic      [mgmt_regs_pkg::ADDR_W-1:0]       dn_addr_o,
	output logic      [mgmt_regs_pkg::DATA_W-1:0]       dn_wdata_o,
	input  wire logic                                   dn_ack_i,
	input  wire logic [mgmt_regs_pkg::DATA_W-1:0]       dn_rdata_i,
	output logic                                        soft_reset_o,
	input  wire logic                                   wake_event_i,
	output logic                                        wake_pin_o,
	output logic                                        wake_pin_oe_o,
	input  wire logic                                   lookup_engine_irq_i,
	output logic                                        irq_o
);
	import mgmt_regs_pkg::*;

	if (SRST_LEN < 1 || SRST_LEN > 255) begin
		$error("soft reset length out of range");
	end

	acc_state_t                 acc_r;
	srst_state_t                srst_r;
	logic [NUM_SRC-1:0]         grant;
	logic [NUM_SRC-1:0]         owner_r;
	logic                       take;
	logic [ADDR_W-1:0]          addr;
	logic [DATA_W-1:0]          wdata;
	logic                       we;
	logic                       from_miim;
	logic [3:0]                 port_f;
	logic [3:0]                 page_f;
	logic [7:0]                 off_f;
	logic                       space_ok;
	logic                       local_hit;
	logic                       fwd;
	logic [DATA_W-1:0]          local_rdata;
	logic                       wake_en_r;
	logic                       wake_pol_r;
	logic                       imask_r;
	logic                       irq_stat;
	logic [7:0]                 srst_cnt_r;

	// fixed priority grant, one access in flight
	always_comb begin
		grant = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (req_valid_i[i]) begin
				grant = '0;
				grant[i] = 1'b1;
			end
		end
		if (acc_r != ACC_IDLE) begin
			grant = '0;
		end
	end

	assign req_ready_o = grant;
	assign take        = |grant;

	// mux of the granted request
	always_comb begin
		addr      = '0;
		wdata     = '0;
		we        = 1'b0;
		from_miim = grant[SRC_MIIM];
		for (int i = 0; i < NUM_SRC; i++) begin
			if (grant[i]) begin
				addr  = req_addr_i[i];
				wdata = req_wdata_i[i];
				we    = req_we_i[i];
			end
		end
	end

	assign port_f = addr[PORT_LSB +: FIELD_W];
	assign page_f = addr[PAGE_LSB +: FIELD_W];
	assign off_f  = addr[7:0];

	// space decode
	always_comb begin
		space_ok = 1'b0;
		if (!addr[TOP_BIT]) begin
			if (port_f == PORT_GLOBAL) begin
				space_ok = (page_f <= GPAGE_LAST);
			end else if (port_f <= PORT_LAST) begin
				space_ok = (page_f <= PPAGE_LAST) && (page_f != PPAGE_RSV_A)
					&& (page_f != PPAGE_RSV_B);
			end
		end
		if (from_miim && !(port_f != PORT_GLOBAL && page_f == PPAGE_PHY)) begin
			space_ok = 1'b0;
		end
	end

	assign local_hit = space_ok && (port_f == PORT_GLOBAL) && (page_f == GPAGE_OPER);
	assign fwd       = space_ok && !local_hit;

	assign irq_stat  = lookup_engine_irq_i;

	// local read mux, one byte per address
	always_comb begin
		local_rdata = '0;
		unique case (off_f)
			OFF_IDENT0:  local_rdata = IDENT_FIXED;
			OFF_IDENT_U: local_rdata = IDENT_UPPER;
			OFF_IDENT_L: local_rdata = IDENT_LOWER;
			OFF_REV_RST: begin
				local_rdata[REV_LSB +: 4] = SILICON_REV;
				local_rdata[SRST_BIT]     = (srst_r == SR_ACTIVE);
			end
			OFF_WAKE: begin
				local_rdata[WAKE_EN_BIT]  = wake_en_r;
				local_rdata[WAKE_POL_BIT] = wake_pol_r;
			end
			OFF_ISTAT:   local_rdata[LOOKUP_IRQ_BIT - 24] = irq_stat;
			OFF_IMASK:   local_rdata[LOOKUP_IRQ_BIT - 24] = imask_r;
			default:     local_rdata = '0;
		endcase
	end

	// access sequencer
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_r   <= ACC_IDLE;
			owner_r <= '0;
		end else begin
			unique case (acc_r)
				ACC_IDLE: begin
					if (take && fwd) begin
						acc_r   <= ACC_WAIT;
						owner_r <= grant;
					end
				end
				ACC_WAIT: begin
					if (dn_ack_i) begin
						acc_r   <= ACC_IDLE;
						owner_r <= '0;
					end
				end
				default: begin
					acc_r   <= ACC_IDLE;
					owner_r <= '0;
				end
			endcase
		end
	end

	// answer to the source
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o   <= '0;
			rdata_o <= '0;
		end else begin
			ack_o <= '0;
			if (take && !fwd) begin
				ack_o   <= grant;
				rdata_o <= (local_hit && !we) ? local_rdata : '0;
			end else if (acc_r == ACC_WAIT && dn_ack_i) begin
				ack_o   <= owner_r;
				rdata_o <= dn_rdata_i;
			end
		end
	end

	// downstream issue for other pages
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			dn_req_o   <= 1'b0;
			dn_we_o    <= 1'b0;
			dn_addr_o  <= '0;
			dn_wdata_o <= '0;
		end else begin
			dn_req_o <= take && fwd;
			if (take && fwd) begin
				dn_we_o    <= we;
				dn_addr_o  <= addr;
				dn_wdata_o <= wdata;
			end
		end
	end

	// writable operation page bits
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_en_r  <= WAKE_EN_RST;
			wake_pol_r <= WAKE_POL_RST;
			imask_r    <= IMASK_RST;
		end else if (take && local_hit && we) begin
			if (off_f == OFF_WAKE) begin
				wake_en_r  <= wdata[WAKE_EN_BIT];
				wake_pol_r <= wdata[WAKE_POL_BIT];
			end
			if (off_f == OFF_IMASK) begin
				imask_r <= wdata[LOOKUP_IRQ_BIT - 24];
			end
		end
	end

	// soft reset pulse, registers untouched
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			srst_r     <= SR_IDLE;
			srst_cnt_r <= '0;
		end else begin
			unique case (srst_r)
				SR_IDLE: begin
					if (take && local_hit && we && off_f == OFF_REV_RST
						&& wdata[SRST_BIT]) begin
						srst_r     <= SR_ACTIVE;
						srst_cnt_r <= 8'(SRST_LEN - 1);
					end
				end
				SR_ACTIVE: begin
					if (srst_cnt_r == 8'h00) begin
						srst_r <= SR_IDLE;
					end else begin
						srst_cnt_r <= srst_cnt_r - 8'h01;
					end
				end
				default: srst_r <= SR_IDLE;
			endcase
		end
	end

	assign soft_reset_o = (srst_r == SR_ACTIVE);

	// wake pin and interrupt outputs
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			wake_pin_o    <= 1'b0;
			wake_pin_oe_o <= 1'b0;
			irq_o         <= 1'b0;
		end else begin
			wake_pin_oe_o <= wake_en_r;
			wake_pin_o    <= wake_event_i ~^ wake_pol_r;
			irq_o         <= irq_stat && !imask_r;
		end
	end

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	sequence s_srst_write;
		take && local_hit && we && off_f == OFF_REV_RST && wdata[SRST_BIT]
			&& srst_r == SR_IDLE;
	endsequence

	sequence s_srst_pulse;
		soft_reset_o [*4];
	endsequence

	AST_SRST_SELF_CLEAR: assert property (
		s_srst_write |=> s_srst_pulse)
		else $error("soft reset pulse too short");

	AST_SRST_ENDS: assert property (
		s_srst_write |-> ##[1:256] !soft_reset_o)
		else $error("soft reset never clears");

	AST_MIIM_PHY_ONLY: assert property (
		take && from_miim && page_f != PPAGE_PHY |-> !fwd && !local_hit)
		else $error("miim reached non-phy space");

	AST_TOP_BIT: assert property (
		take && addr[TOP_BIT] |=> !dn_req_o && rdata_o == 8'h00)
		else $error("bit fifteen address decoded");

	AST_RSV_PORT_PAGE: assert property (
		take && port_f != PORT_GLOBAL && (page_f == PPAGE_RSV_B || page_f > PPAGE_LAST)
		|=> !dn_req_o)
		else $error("reserved port page forwarded");

	AST_RSV_GLOBAL: assert property (
		take && port_f == PORT_GLOBAL && page_f > GPAGE_LAST |=> !dn_req_o)
		else $error("reserved global page forwarded");

	AST_IDENT_READ: assert property (
		take && local_hit && !we && off_f == OFF_IDENT_U |=> rdata_o == IDENT_UPPER)
		else $error("upper identification byte wrong");

	AST_REV_READ: assert property (
		take && local_hit && !we && off_f == OFF_REV_RST
		|=> rdata_o[7:4] == SILICON_REV && rdata_o[3:1] == 3'b000)
		else $error("revision byte wrong");

	AST_WAKE_PIN: assert property (
		$past(wake_pol_r) == 1'b0 && $past(wake_event_i) |-> !wake_pin_o)
		else $error("wake pin polarity wrong");

	AST_IRQ_FOLLOWS: assert property (
		lookup_engine_irq_i && !imask_r |=> irq_o)
		else $error("unmasked interrupt not raised");

	AST_IRQ_MASKED: assert property (
		imask_r && $stable(imask_r) |=> !irq_o)
		else $error("masked interrupt raised");

	AST_LOCAL_ANSWER: assert property (
		take && !fwd |=> ack_o == $past(grant))
		else $error("local access not answered next cycle");
endmodule
`default_nettype wire

// [testbench/downstream_model.sv]
`default_nettype none
module downstream_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        dn_req_i,
	input  wire logic [15:0] dn_addr_i,
	output logic             dn_ack_o,
	output logic [7:0]       dn_rdata_o,
	output int               hits_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// answer delay from low address bits: one cycle up to four
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 0;
			hits_o <= 0;
			dn_ack_o <= 1'b0;
			dn_rdata_o <= 8'h00;
		end else begin
			dn_ack_o <= 1'b0;
			dn_rdata_o <= dn_rdata_o + 8'h3b;
			if (dn_req_i) begin
				cnt <= int'(dn_addr_i[1:0]) + 1;
				hits_o <= hits_o + 1;
			end else if (cnt > 1) begin
				cnt <= cnt - 1;
			end else if (cnt == 1) begin
				cnt <= 0;
				dn_ack_o <= 1'b1;
				dn_rdata_o <= dn_addr_i[7:0] ^ 8'h5c;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/test_switch_mgmt_register_map_global.sv]
`default_nettype none
module test_switch_mgmt_register_map_global;
	timeunit 1ns;
	timeprecision 1ps;
	import mgmt_regs_pkg::*;
	localparam int unsigned SRL = 4;
	localparam logic [7:0] ID0 = 8'h11; // arbitrary value
	localparam logic [7:0] IDU = 8'h5a; // arbitrary value
	localparam logic [7:0] IDL = 8'h3c; // arbitrary value
	localparam logic [3:0] REV = 4'h1; // arbitrary value
	logic mclk_i, rst_i, dn_ack_i, wake_event_i, lookup_engine_irq_i;
	logic dn_req_o, dn_we_o, soft_reset_o, wake_pin_o, wake_pin_oe_o, irq_o;
	logic [3:0] req_valid_i, req_we_i, req_ready_o, ack_o;
	logic [15:0] req_addr_i [4];
	logic [15:0] dn_addr_o;
	logic [7:0] req_wdata_i [4];
	logic [7:0] rdata_o, dn_wdata_o, dn_rdata_i, q;
	logic [15:0] rsv [7] = '{16'h8001, 16'h0500, 16'h0fff, 16'h1200, 16'h1700, 16'h1c00, 16'h0011};
	int errors, checks, cyc, hits, h0, n;

	mgmt_regs #(.IDENT_FIXED(ID0), .IDENT_UPPER(IDU), .IDENT_LOWER(IDL),
		.SILICON_REV(REV), .SRST_LEN(SRL)) i_dut (.mclk_i, .rst_i, .req_valid_i,
		.req_we_i, .req_addr_i, .req_wdata_i, .req_ready_o, .ack_o, .rdata_o, .dn_req_o,
		.dn_we_o, .dn_addr_o, .dn_wdata_o, .dn_ack_i, .dn_rdata_i, .soft_reset_o,
		.wake_event_i, .wake_pin_o, .wake_pin_oe_o, .lookup_engine_irq_i, .irq_o);
	downstream_model i_far (.mclk_i, .rst_i, .dn_req_i(dn_req_o), .dn_addr_i(dn_addr_o),
		.dn_ack_o(dn_ack_i), .dn_rdata_o(dn_rdata_i), .hits_o(hits));

	initial begin
		mclk_i = 1'b0;
		forever #2 mclk_i = ~mclk_i;
	end

	task automatic tally_and_finish;
		if (errors == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until granted, released on the taking edge
	task automatic acc(input int s, input logic we, input logic [15:0] a, input logic [7:0] d);
		int k;
		@(posedge mclk_i);
		req_valid_i[s] <= 1'b1;
		req_we_i[s] <= we;
		req_addr_i[s] <= a;
		req_wdata_i[s] <= d;
		k = 0;
		do begin
			@(negedge mclk_i);
			k++;
		end while (req_ready_o[s] !== 1'b1 && k < 50);
		@(posedge mclk_i);
		req_valid_i[s] <= 1'b0;
		do begin
			@(negedge mclk_i);
			k++;
		end while (ack_o[s] !== 1'b1 && k < 100);
		q = rdata_o;
		if (k >= 100)
			chk(8'hee, 8'h00);
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		acc(0, 1'b0, a, 8'h00);
		chk(q, exp);
	endtask

	// read first, or in the wanted bits, write back
	task automatic rmw(input logic [15:0] a, input logic [7:0] set);
		acc(0, 1'b0, a, 8'h00);
		acc(0, 1'b1, a, q | set);
	endtask

	task automatic t_ident;
		rd(16'h0003, {REV, 4'h0});
		rd(16'h0006, 8'h00);
		rd(16'h0014, 8'h00);
		acc(0, 1'b1, 16'h0001, 8'hff);
		rd(16'h0002, IDL);
		rd(16'h0000, ID0);
		rd(16'h0001, IDU);
	endtask

	task automatic t_sources;
		for (int s = 0; s < 3; s++) begin
			acc(s, 1'b0, 16'h0001, 8'h00);
			chk(q, IDU);
		end
		acc(3, 1'b0, 16'h0001, 8'h00);
		chk(q, 8'h00);
		h0 = hits;
		acc(3, 1'b0, 16'h1103, 8'h00);
		chk(q, 8'h03 ^ 8'h5c);
		chk(8'(hits - h0), 8'h01);
	endtask

	task automatic t_decode;
		rd(16'h7b10, 8'h10 ^ 8'h5c);
		chk(dn_addr_o[15:8], 8'h7b);
		rd(16'h0102, 8'h02 ^ 8'h5c);
		acc(0, 1'b1, 16'h1300, 8'ha5);
		chk({7'h0, dn_we_o}, 8'h01);
		chk(dn_wdata_o, 8'ha5);
		chk(dn_addr_o[15:8], 8'h13);
		h0 = hits;
		foreach (rsv[i])
			rd(rsv[i], 8'h00);
		chk(8'(hits - h0), 8'h00);
	endtask

	task automatic t_wake;
		@(posedge mclk_i);
		wake_event_i <= 1'b1;
		rmw(16'h0006, 8'h03);
		rd(16'h0006, 8'h03);
		chk({7'h0, wake_pin_o}, 8'h01);
		chk({7'h0, wake_pin_oe_o}, 8'h01);
		acc(0, 1'b1, 16'h0006, 8'h02);
		@(negedge mclk_i);
		chk({7'h0, wake_pin_o}, 8'h00);
		acc(0, 1'b1, 16'h0006, 8'h00);
		@(negedge mclk_i);
		chk({7'h0, wake_pin_oe_o}, 8'h00);
		@(posedge mclk_i);
		wake_event_i <= 1'b0;
		acc(0, 1'b1, 16'h0006, 8'h02);
	endtask

	task automatic t_irq;
		@(posedge mclk_i);
		lookup_engine_irq_i <= 1'b1;
		rd(16'h0010, 8'h80);
		rd(16'h0013, 8'h00);
		chk({7'h0, irq_o}, 8'h01);
		rmw(16'h0014, 8'h80);
		@(negedge mclk_i);
		chk({7'h0, irq_o}, 8'h00);
		rd(16'h0014, 8'h80);
		rd(16'h0017, 8'h00);
		acc(0, 1'b1, 16'h0014, 8'h00);
		@(posedge mclk_i);
		lookup_engine_irq_i <= 1'b0;
		rd(16'h0010, 8'h00);
		chk({7'h0, irq_o}, 8'h00);
	endtask

	task automatic t_srst;
		acc(0, 1'b1, 16'h0003, 8'h01);
		n = 0;
		while (soft_reset_o === 1'b1 && n < 50) begin
			n++;
			@(negedge mclk_i);
		end
		chk(8'(n), 8'(SRL));
		rd(16'h0003, {REV, 4'h0});
		rd(16'h0006, 8'h02);
	endtask

	initial begin
		rst_i = 1'b1;
		req_valid_i = 4'h0;
		req_we_i = 4'h0;
		req_addr_i = '{default: 16'h0000};
		req_wdata_i = '{default: 8'h00};
		wake_event_i = 1'b0;
		lookup_engine_irq_i = 1'b0;
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_ident();
		t_sources();
		t_decode();
		t_wake();
		t_irq();
		t_srst();
		tally_and_finish();
	end
endmodule
`default_nettype wire
